/* rtl/waveform_measurement_engine.sv */
// Measurement engine: levels, zone, crossings, area and burst width.
// Assumes a sample memory answering a read one cycle later and a host
// on a plain register port; one clock, asynchronous active-low reset.
// Summary of operation
// RULE_01 - Min-max: high is max, low is min
// RULE_02 - Histogram has one bin per level, 256
// RULE_03 - Split histogram halfway between min and max
// RULE_04 - Peak bins of each half give high, low
// RULE_05 - Halfway bin peaking returns it for both; code returns it once it beats either half's peak bin
// RULE_06 - Ties pick bin farthest from halfway
// RULE_07 - Four reference levels settable 0 to 100
// RULE_08 - Zone starts at 0 or left cursor
// RULE_09 - Zone ends at length-1 or right cursor
// RULE_10 - Hysteresis band is tenth of amplitude
// RULE_11 - Rearm only after passing beyond the band
// RULE_12 - First zone crossing, either direction, is first
// RULE_13 - Second opposite, third same as first
// RULE_14 - First direction stored, valid only once found
// RULE_15 - Cycle spans first to third crossing
// RULE_16 - Time zero is sample before trigger
// RULE_17 - Trigger fraction captured, zero adds it
// RULE_18 - Amplitude is high minus low
// RULE_19 - Area over zone, single point gives value
// RULE_20 - Cycle area over cycle, same corner case
// RULE_21 - Burst width is last minus first crossing
// RULE_22 - Missing crossings mark results invalid
// RULE_23 - Host holds options steady during a run
//
// The implementer's own choices: the plain strobed port and the register addresses.
`include "wme_map.svh"
`timescale 1ns/1ps
`default_nettype none
module waveform_measurement_engine #(
  parameter int SW = `WME_SW_DEF
) (
  input  wire logic            clk,
  input  wire logic            arst_n,
  input  wire logic [`WME_AW-1:0] addr,
  input  wire logic [31:0]     wrData,
  input  wire logic            wrEn,
  input  wire logic            rdEn,
  output logic      [31:0]     rdData,
  output logic      [SW-1:0]   memAddr,
  output logic                 memRd,
  input  wire logic [7:0]      memData,
  input  wire logic            trigStrobe,
  input  wire logic [SW-1:0]   trigSample,
  input  wire logic [7:0]      trigFraction,
  output logic                 busy
);
  // Cursor fields and result views carry 16-bit sample indices
  if (SW < 2 || SW > 16) begin : g_chk
    $error("SW out of range");
  end
  wme_pkg::state_t state_r, state_nxt;
  logic          method_r, gate_r, done_r;
  logic [31:0]   refs_r;
  logic [SW-1:0] sampleCount_r, curL_r, curR_r;
  logic [SW-1:0] timeZeroPosition_r;
  logic [7:0]    triggerFractionOffset_r;
  logic [8:0]    bin_r;
  logic          dVld_r;
  logic [SW-1:0] dIdx_r;
  logic [7:0]    min_r, max_r, firstS_r, lastS_r;
  logic [31:0]   sum_r;
  logic [SW:0]   hist [256];
  logic [SW:0]   upCnt_r, loCnt_r, midCnt_r;
  logic [7:0]    upBin_r, loBin_r, high_r, low_r;
  logic [7:0]    prev_r;
  logic          prevOk_r, armRise_r, armFall_r;
  logic [1:0]    cnt_r;
  wme_pkg::cross_t c1_r, c2_r, c3_r, lastX_r;
  logic [31:0]   cycSum_r, area_r, cycArea_r, burst_r;
  logic [7:0]    cycFirst_r, cycLast_r;
  // Register port decode
  wire wCtrl = wrEn && addr == `WME_R_CTRL;
  wire wRefs = wrEn && addr == `WME_R_REFS;
  wire wRlen = wrEn && addr == `WME_R_RLEN;
  wire wCurs = wrEn && addr == `WME_R_CURS;
  wire idle  = state_r == wme_pkg::ST_IDLE;
  wire goStart = wCtrl && wrData[`WME_B_GO] && idle;
  // Measurement zone; a reversed cursor pair collapses to one sample
  wire [SW-1:0] zStart = gate_r ? curL_r : '0;                    // see RULE_08
  wire [SW-1:0] zEndRaw = gate_r ? curR_r : sampleCount_r - 1'b1; // see RULE_09
  wire [SW-1:0] zEnd = (zEndRaw < zStart) ? zStart : zEndRaw;
  wire lastD = dVld_r && dIdx_r == zEnd;
  wire scanA = state_r == wme_pkg::ST_SCANA;
  wire scanB = state_r == wme_pkg::ST_SCANB;
  wire inHist = state_r == wme_pkg::ST_HIST;
  wire histDone = inHist && bin_r[8];
  wire clrDone = state_r == wme_pkg::ST_CLR && bin_r[7:0] == `WME_BIN_LAST;
  // Histogram split point and mid-bin decision
  wire [8:0] mmSum = {1'b0, min_r} + {1'b0, max_r};
  wire [7:0] midC = mmSum[8:1];                                   // see RULE_03
  wire [SW:0] hb = hist[bin_r[7:0]];
  wire midWins = midCnt_r > upCnt_r || midCnt_r > loCnt_r;        // see RULE_05
  wire [7:0] highSel = !method_r ? max_r : midWins ? midC : upBin_r; // see RULE_01
  wire [7:0] lowSel = !method_r ? min_r : midWins ? midC : loBin_r;  // see RULE_04
  // Derived levels from the chosen high and low
  wire [7:0] amp = high_r - low_r;                                // see RULE_18
  wire [31:0] hysP = {24'h000000, amp} * `WME_HYS_MUL;
  wire [7:0] hyst = 8'(hysP >> `WME_HYS_SH);                      // see RULE_10
  // Percent settings above 100 are clipped to the full amplitude
  function automatic [7:0] lvl(input [6:0] p, input [7:0] a, input [7:0] lo);
    logic [6:0] pc;
    logic [31:0] pr;
    pc = (p > `WME_PCT_MAX) ? `WME_PCT_MAX : p;
    pr = ({24'h000000, a} * {25'h0000000, pc}) * `WME_PCT_MUL;
    lvl = lo + 8'(pr >> `WME_PCT_SH);
  endfunction
  wire [7:0] upLvl = lvl(refs_r[6:0], amp, low_r);                // see RULE_07
  wire [7:0] midLvl = lvl(refs_r[14:8], amp, low_r);
  wire [7:0] loLvl = lvl(refs_r[22:16], amp, low_r);
  wire [7:0] mid2Lvl = lvl(refs_r[30:24], amp, low_r);
  // Crossing detection on the returning sample
  wire [9:0] xs = {2'b00, memData};
  wire [9:0] hiT = {2'b00, midLvl} + {2'b00, hyst};
  wire [9:0] xsUp = xs + {2'b00, hyst}; // Sample plus band; a wide band cannot wrap
  wire sBelow = memData < midLvl;
  wire pBelow = prev_r < midLvl;
  wire rise = scanB && dVld_r && prevOk_r && armRise_r && pBelow && !sBelow;
  wire fall = scanB && dVld_r && prevOk_r && armFall_r && !pBelow && sBelow;
  wire anyX = rise || fall;
  wire takeX2 = anyX && cnt_r == 2'd1 && rise != c1_r.rise;       // see RULE_13
  wire takeX3 = anyX && cnt_r == 2'd2 && rise == c1_r.rise;
  wire inCyc = scanB && dVld_r && (cnt_r == 2'd1 || cnt_r == 2'd2);
  wire [31:0] idx32 = 32'(dIdx_r);
  // Sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      wme_pkg::ST_IDLE:  if (goStart) state_nxt = wme_pkg::ST_CLR;
      wme_pkg::ST_CLR:   if (clrDone) state_nxt = wme_pkg::ST_SCANA;
      wme_pkg::ST_SCANA: if (lastD) state_nxt = wme_pkg::ST_HIST;
      wme_pkg::ST_HIST:  if (bin_r[8]) state_nxt = wme_pkg::ST_SCANB;
      wme_pkg::ST_SCANB: if (lastD) state_nxt = wme_pkg::ST_FIN;
      wme_pkg::ST_FIN:   state_nxt = wme_pkg::ST_IDLE;
    endcase
  end
  wire binRun = (state_r == wme_pkg::ST_CLR && !clrDone) || (inHist && !bin_r[8]);
  wire [8:0] bin_nxt = binRun ? bin_r + 9'h001 : 9'h000;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= wme_pkg::ST_IDLE;
      bin_r   <= 9'h000;
      busy    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bin_r   <= bin_nxt;
      busy    <= state_nxt != wme_pkg::ST_IDLE;
    end
  end
  // Host-written configuration; options assumed steady while busy
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      method_r      <= 1'b0;
      gate_r        <= 1'b0;
      refs_r        <= `WME_REFS_RST;
      sampleCount_r <= SW'(`WME_RLEN_RST);
      curL_r        <= '0;
      curR_r        <= '0;
    end else begin
      if (wCtrl) method_r <= wrData[`WME_B_HIST];                 // see RULE_23
      if (wCtrl) gate_r <= wrData[`WME_B_GATE];
      if (wRefs) refs_r <= wrData;
      if (wRlen) sampleCount_r <= wrData[SW-1:0];
      if (wCurs) curL_r <= wrData[SW-1:0];
      if (wCurs) curR_r <= wrData[16+SW-1:16];
    end
  end
  // Trigger capture: position of the sample before it, plus fraction
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timeZeroPosition_r      <= '0;
      triggerFractionOffset_r <= 8'h00;
    end else if (trigStrobe) begin
      timeZeroPosition_r      <= trigSample;                      // see RULE_16
      triggerFractionOffset_r <= trigFraction;                    // see RULE_17
    end
  end
  // Memory read walker, reused by both passes
  wire scanGo = clrDone || histDone;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      memRd   <= 1'b0;
      memAddr <= '0;
      dVld_r  <= 1'b0;
      dIdx_r  <= '0;
    end else begin
      memRd   <= scanGo || (memRd && memAddr != zEnd);
      memAddr <= scanGo ? zStart : memRd ? memAddr + 1'b1 : memAddr;
      dVld_r  <= memRd;
      dIdx_r  <= memAddr;
    end
  end
  // Histogram storage: cleared bin by bin, then one count per sample
  always_ff @(posedge clk) begin
    if (state_r == wme_pkg::ST_CLR) begin
      hist[bin_r[7:0]] <= '0;
    end else if (scanA && dVld_r) begin
      hist[memData] <= hist[memData] + 1'b1;                      // see RULE_02
    end
  end
  // First pass: extremes, zone sum and end samples
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      min_r    <= 8'hFF;
      max_r    <= 8'h00;
      sum_r    <= 32'h00000000;
      firstS_r <= 8'h00;
      lastS_r  <= 8'h00;
    end else if (goStart) begin
      min_r <= 8'hFF;
      max_r <= 8'h00;
      sum_r <= 32'h00000000;
    end else if (scanA && dVld_r) begin
      if (memData < min_r) min_r <= memData;                      // see RULE_01
      if (memData > max_r) max_r <= memData;
      sum_r <= sum_r + {24'h000000, memData};                     // see RULE_19
      if (dIdx_r == zStart) firstS_r <= memData;
      if (lastD) lastS_r <= memData;
    end
  end
  // Peak search: ascending scan, upper ties move outward, lower do not
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      upCnt_r  <= '0;
      loCnt_r  <= '0;
      midCnt_r <= '0;
      upBin_r  <= 8'h00;
      loBin_r  <= 8'h00;
    end else if (clrDone) begin
      upCnt_r  <= '0;
      loCnt_r  <= '0;
      midCnt_r <= '0;
      upBin_r  <= 8'h00;
      loBin_r  <= 8'h00;
    end else if (inHist && !bin_r[8]) begin
      if (bin_r[7:0] > midC && hb >= upCnt_r) begin               // see RULE_06
        upCnt_r <= hb;
        upBin_r <= bin_r[7:0];
      end
      if (bin_r[7:0] < midC && hb > loCnt_r) begin                // see RULE_06
        loCnt_r <= hb;
        loBin_r <= bin_r[7:0];
      end
      if (bin_r[7:0] == midC) midCnt_r <= hb;
    end
  end
  // Level choice at the end of the peak search
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      high_r <= 8'h00;
      low_r  <= 8'h00;
    end else if (histDone) begin
      high_r <= highSel;                                          // see RULE_04
      low_r  <= lowSel;
    end
  end
  // Second pass: hysteresis arming; a crossing disarms both ways
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_r    <= 8'h00;
      prevOk_r  <= 1'b0;
      armRise_r <= 1'b1;
      armFall_r <= 1'b1;
    end else if (histDone) begin
      prevOk_r  <= 1'b0;
      armRise_r <= 1'b1;
      armFall_r <= 1'b1;
    end else if (scanB && dVld_r) begin
      prev_r   <= memData;
      prevOk_r <= 1'b1;
      if (anyX) begin
        armRise_r <= 1'b0;                                        // see RULE_11
        armFall_r <= 1'b0;
      end else begin
        if (xsUp < {2'b00, midLvl}) armRise_r <= 1'b1;            // see RULE_11
        if (xs > hiT) armFall_r <= 1'b1;
      end
    end
  end
  // Crossing bookkeeping cleared at start; cycle sum loaded at the first crossing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r      <= 2'd0;
      c1_r       <= '0;
      c2_r       <= '0;
      c3_r       <= '0;
      lastX_r    <= '0;
      cycSum_r   <= 32'h00000000;
      cycFirst_r <= 8'h00;
      cycLast_r  <= 8'h00;
    end else if (goStart) begin
      cnt_r   <= 2'd0;
      c1_r    <= '0;                                              // see RULE_22
      c2_r    <= '0;
      c3_r    <= '0;
      lastX_r <= '0;
    end else begin
      if (anyX && cnt_r == 2'd0) begin
        c1_r       <= '{ok: 1'b1, rise: rise, t: idx32};          // see RULE_12
        cnt_r      <= 2'd1;
        cycSum_r   <= {24'h000000, memData};
        cycFirst_r <= memData;
      end else if (inCyc) begin
        cycSum_r <= cycSum_r + {24'h000000, memData};             // see RULE_20
      end
      if (takeX2) begin
        c2_r  <= '{ok: 1'b1, rise: rise, t: idx32};
        cnt_r <= 2'd2;
      end
      if (takeX3) begin
        c3_r      <= '{ok: 1'b1, rise: rise, t: idx32};           // see RULE_15
        cnt_r     <= 2'd3;
        cycLast_r <= memData;
      end
      // Latest crossing equals the first met searching backward
      if (anyX) lastX_r <= '{ok: 1'b1, rise: rise, t: idx32};     // see RULE_21
    end
  end
  // Results; trapezoid sums kept in half sample-level units
  wire [31:0] areaV = (zStart == zEnd) ? {23'h000000, firstS_r, 1'b0}
                    : (sum_r << 1) - {24'h000000, firstS_r} - {24'h000000, lastS_r};
  wire [31:0] cycV = (c1_r.t == c3_r.t) ? {23'h000000, cycFirst_r, 1'b0}
                   : (cycSum_r << 1) - {24'h000000, cycFirst_r} - {24'h000000, cycLast_r};
  wire fin = state_r == wme_pkg::ST_FIN;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      area_r    <= 32'h00000000;
      cycArea_r <= 32'h00000000;
      burst_r   <= 32'h00000000;
      done_r    <= 1'b0;
    end else if (goStart) begin
      done_r <= 1'b0;
    end else if (fin) begin
      area_r    <= areaV;                                         // see RULE_19
      cycArea_r <= c3_r.ok ? cycV : 32'h00000000;                 // see RULE_20
      burst_r   <= lastX_r.t - c1_r.t;                            // see RULE_21
      done_r    <= 1'b1;
    end
  end
  // Read view; direction only meaningful with its valid bit
  wire [31:0] statW = {24'h000000, c1_r.rise, lastX_r.ok, c3_r.ok,
                       c2_r.ok, c1_r.ok, done_r, busy, 1'b0};     // see RULE_14
  logic [31:0] rv [16];
  assign rv = '{{29'h00000000, gate_r, method_r, 1'b0}, refs_r, 32'(sampleCount_r),
                {16'(curR_r), 16'(curL_r)}, statW, {hyst, amp, low_r, high_r},
                {mid2Lvl, loLvl, midLvl, upLvl}, {c2_r.t[15:0], c1_r.t[15:0]},
                {lastX_r.t[15:0], c3_r.t[15:0]}, area_r, cycArea_r, burst_r,
                {8'h00, triggerFractionOffset_r, 16'(timeZeroPosition_r)},
                32'h00000000, 32'h00000000, 32'h00000000};
  // Read data stand for one cycle only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData <= 32'h00000000;
    end else begin
      rdData <= rdEn ? rv[addr] : 32'h00000000;
    end
  end
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_minmax_levels: assert property (histDone && !method_r |=> // see RULE_01
    high_r == $past(max_r) && low_r == $past(min_r))
    else $error("min-max levels wrong");
  a_hist_span: assert property (inHist && !bin_r[8] |=> // see RULE_02
    bin_r == $past(bin_r) + 9'h001)
    else $error("histogram scan skipped a bin");
  a_mid_split: assert property (histDone && method_r && !midWins |=> // see RULE_03
    high_r > $past(midC) && low_r < $past(midC))
    else $error("levels on wrong side of split");
  a_mid_both: assert property (histDone && method_r && midWins |=> // see RULE_05
    high_r == low_r && high_r == $past(midC))
    else $error("mid bin not returned for both");
  a_zone_first: assert property (scanGo |=> memRd && memAddr == $past(zStart)) // see RULE_08
    else $error("scan did not begin at zone start");
  a_zone_last: assert property (memRd && memAddr == zEnd |=> !memRd) // see RULE_09
    else $error("scan ran past zone end");
  a_hyst_rearm: assert property (rise |=> !armRise_r && !armFall_r) // see RULE_11
    else $error("crossing did not disarm");
  a_cross_alt: assert property (c2_r.ok && c1_r.ok |-> c2_r.rise != c1_r.rise) // see RULE_13
    else $error("second crossing same polarity");
  a_trig_cap: assert property (trigStrobe |=> // see RULE_17
    triggerFractionOffset_r == $past(trigFraction) &&
    timeZeroPosition_r == $past(trigSample))
    else $error("trigger offset not captured");
  a_amp_diff: assert property (fin |-> high_r >= low_r && // see RULE_18
    (method_r || amp == 8'(max_r - min_r)))
    else $error("amplitude mismatch");
  a_invalid_cyc: assert property (fin && !c3_r.ok |=> // see RULE_22
    cycArea_r == 32'h00000000 ##1 !c3_r.ok)
    else $error("cycle area reported without cycle");
  c_hist_run: cover property (histDone && method_r ##[1:1000] fin);
  c_three_x: cover property (takeX3);
  c_mid_wins: cover property (histDone && method_r && midWins);
  c_gated: cover property (goStart && gate_r);
endmodule
`default_nettype wire

/* shared/wme_map.svh */
// Register map, field positions, reset values and arithmetic constants
// of the waveform measurement engine; definitions only.
`ifndef WME_MAP_SVH
`define WME_MAP_SVH
`define WME_SW_DEF   16
`define WME_AW       4
// Register indices on the plain register port
`define WME_R_CTRL   4'h0
`define WME_R_REFS   4'h1
`define WME_R_RLEN   4'h2
`define WME_R_CURS   4'h3
`define WME_R_STAT   4'h4
`define WME_R_LVL    4'h5
`define WME_R_RLVL   4'h6
`define WME_R_X12    4'h7
`define WME_R_X3L    4'h8
`define WME_R_AREA   4'h9
`define WME_R_CAREA  4'hA
`define WME_R_BURST  4'hB
`define WME_R_TRIG   4'hC
// Control bits
`define WME_B_GO     0
`define WME_B_HIST   1
`define WME_B_GATE   2
// Reset values: references 90/50/10/50 percent
`define WME_REFS_RST 32'h320A325A
`define WME_RLEN_RST 16'h0400
// Percent to level: x*656>>16 approximates x/100
`define WME_PCT_MAX  7'h64
`define WME_PCT_MUL  32'h00000290
`define WME_PCT_SH   16
// Hysteresis: amp*205>>11 is floor(amp/10) for 8-bit amplitudes
`define WME_HYS_MUL  32'h000000CD
`define WME_HYS_SH   11
`define WME_BIN_LAST 8'hFF
`endif

/* shared/wme_pkg.sv */
// Types shared by the waveform measurement engine.
// Assumes the map header for numbers; this holds types only.
`default_nettype none
package wme_pkg;
  // Gray along IDLE-CLR-SCANA-HIST-SCANB-FIN-IDLE
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_CLR   = 3'h1,
    ST_SCANA = 3'h3,
    ST_HIST  = 3'h2,
    ST_SCANB = 3'h6,
    ST_FIN   = 3'h4
  } state_t;
  // One located crossing
  typedef struct packed {
    logic        ok;
    logic        rise;
    logic [31:0] t;
  } cross_t;
endpackage
`default_nettype wire

/* sim/sample_memory_model.sv */
// Acquisition memory model: answers a sample read one cycle later.
// Assumes the bench loads mem[] before a run; 64 words are enough here.
`timescale 1ns/1ps
`default_nettype none
module sample_memory_model #(
  parameter int SW = 16
) (
  input  wire logic          clk,
  input  wire logic [SW-1:0] memAddr,
  input  wire logic          memRd,
  output logic      [7:0]    memData
);
  logic [7:0] mem [0:63];
  initial memData = 8'h00;
  // Idle cycles invert memData every cycle, so a stale sample alternates with its inverse
  always @(posedge clk) begin
    if (memRd) begin
      memData <= mem[memAddr[5:0]];
    end else begin
      memData <= ~memData;
    end
  end
endmodule
`default_nettype wire

/* sim/test_waveform_measurement_engine.sv */
// Self-checking bench for the measurement engine.
// Assumes the sample memory model and the map header on the include path.
`include "wme_map.svh"
`timescale 1ns/1ps
`default_nettype none
module test_waveform_measurement_engine;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wrData = 32'h0;
  logic        wrEn = 1'b0;
  logic        rdEn = 1'b0;
  logic [31:0] rdData;
  logic [15:0] memAddr;
  logic        memRd;
  logic [7:0]  memData;
  logic        trigStrobe = 1'b0;
  logic [15:0] trigSample = 16'h0;
  logic [7:0]  trigFraction = 8'h0;
  logic        busy;
  logic        memRdQ = 1'b0;
  logic [15:0] firstAddr;
  logic [15:0] lastAddr;
  logic [7:0]  wave [0:31];
  int          failures = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  logic [31:0] v;

  waveform_measurement_engine u_dut (.clk(clk), .arst_n(arst_n), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .memAddr(memAddr),
    .memRd(memRd), .memData(memData), .trigStrobe(trigStrobe), .trigSample(trigSample),
    .trigFraction(trigFraction), .busy(busy));
  sample_memory_model u_mem (.clk(clk), .memAddr(memAddr), .memRd(memRd), .memData(memData));

  initial begin
    forever #2 clk = ~clk;
  end

  // Zone bounds seen on the memory link, and a hang guard
  always @(posedge clk) begin
    if (memRd && !memRdQ) firstAddr <= memAddr;
    if (memRd) lastAddr <= memAddr;
    memRdQ <= memRd;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    @(negedge clk);
    d = rdData;
  endtask

  // Options stay untouched from start until busy drops
  task automatic run(input logic [31:0] ctrl);
    int n;
    n = 0;
    wr(`WME_R_CTRL, ctrl);
    @(negedge clk);
    chk("busy", 32'h1, {31'h0, busy});
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n == 3000) chk("run end", 32'h0, 32'h1);
  endtask

  // Trapezoid area in doubled units, from the bench's own copy of the record
  function automatic logic [31:0] area2(input int a, input int b);
    logic [31:0] s;
    s = 32'h0;
    for (int i = a; i < b; i++) s = s + 32'(wave[i]) + 32'(wave[i+1]);
    return s;
  endfunction

  task automatic t_reset();
    rd(`WME_R_REFS, v); chk("refs rst", `WME_REFS_RST, v);
    rd(`WME_R_RLEN, v); chk("rlen rst", 32'h00000400, v);
    rd(4'hD, v); chk("unmapped", 32'h0, v);
  endtask

  // Spiky square wave with a dip below the mid level inside the high half
  task automatic t_minmax();
    wr(`WME_R_RLEN, 32'h20);
    wr(`WME_R_REFS, 32'h00003264);
    rd(`WME_R_REFS, v); chk("refs", 32'h00003264, v);
    run(32'h1);
    rd(`WME_R_LVL, v); chk("lvl mm", 32'h18F505FA, v);
    rd(`WME_R_RLVL, v); chk("rlvl", 32'h05057FFA, v);
    rd(`WME_R_STAT, v); chk("stat", 32'h000000FC, v);
    rd(`WME_R_X12, v); chk("x12", 32'h000C0008, v);
    rd(`WME_R_X3L, v); chk("x3l", 32'h00180018, v);
    rd(`WME_R_AREA, v); chk("area", area2(0, 31), v);
    rd(`WME_R_CAREA, v); chk("carea", area2(8, 24), v);
    rd(`WME_R_BURST, v); chk("burst", 32'h10, v);
    chk("zone lo", 32'h0, {16'h0, firstAddr});
    chk("zone hi", 32'h1F, {16'h0, lastAddr});
  endtask

  task automatic t_hist();
    run(32'h3);
    rd(`WME_R_LVL, v); chk("lvl hist", 32'h14C814DC, v);
    rd(`WME_R_CTRL, v); chk("ctrl", 32'h2, v);
  endtask

  // One-sample gated zone holds no crossing
  task automatic t_gate();
    wr(`WME_R_CURS, 32'h000A000A);
    run(32'h5);
    rd(`WME_R_AREA, v); chk("area pt", 32'h000001B8, v);
    rd(`WME_R_STAT, v); chk("stat gate", 32'h4, v & 32'h7F);
    chk("gate lo", 32'hA, {16'h0, firstAddr});
    chk("gate hi", 32'hA, {16'h0, lastAddr});
    // Histogram on one sample: the halfway bin wins both levels
    wr(`WME_R_CURS, 32'h000C000C);
    run(32'h7);
    rd(`WME_R_LVL, v); chk("lvl mid", 32'h00006E6E, v);
    // Samples 12..16: lower bins 0x14 and 0x6E tie, the outer one wins
    wr(`WME_R_CURS, 32'h0010000C);
    run(32'h7);
    rd(`WME_R_LVL, v); chk("lvl tie", 32'h14C814DC, v);
  endtask

  task automatic t_trig();
    @(posedge clk);
    trigStrobe <= 1'b1;
    trigSample <= 16'h0123;
    trigFraction <= 8'h80;
    @(posedge clk);
    trigStrobe <= 1'b0;
    rd(`WME_R_TRIG, v); chk("trig", 32'h00800123, v & 32'h00FFFFFF);
  endtask

  initial begin
    for (int i = 0; i < 32; i++) wave[i] = ((i / 8) % 2 == 1) ? 8'hDC : 8'h14;
    wave[0] = 8'h05;
    wave[12] = 8'h6E;
    wave[31] = 8'hFA;
    for (int i = 0; i < 32; i++) u_mem.mem[i] = wave[i];
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_minmax();
    t_hist();
    t_gate();
    t_trig();
    finish_test();
  end
endmodule
`default_nettype wire
